// ---- rtl/pcp_fifo.sv ----
// synchronous fifo with registered read data, valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module pcp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != FULL_COUNT);
  assign push = in_valid && in_ready;
  // output register refills whenever it is empty or being taken
  assign pop = (count_reg != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop) begin
        count_reg <= (AW+1)'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= (AW+1)'(count_reg - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : pcp_fifo

// ---- rtl/pcp_top.sv ----
// parallel configuration and readback port with bus width detection
// assumes the clock, select, direction, init, mode strap and data pins are asynchronous, the other inputs synchronous; nrst is the program reset
`timescale 1ns/1ps
module pcp_top (
  // system
  input wire logic clk_sys,
  input wire logic nrst,
  // configuration clock pin
  input wire logic cfg_clock_in,
  output logic cfg_clock_out,
  output logic cfg_clock_oe,
  // parallel data bus
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [31:0] data_oe,
  // bus control
  input wire logic cs_n,
  input wire logic read_write_n,
  output logic busy,
  output logic chain_select_out_n,
  // status pins
  output logic done,
  input wire logic init_in,
  output logic init_out,
  output logic init_oe,
  output logic [1:0] revision_select,
  output logic [1:0] revision_select_oe,
  // straps and options
  input wire logic master_mode,
  input wire logic fallback_option,
  input wire logic multi_image_en,
  input wire logic multi_image_req,
  input wire logic [1:0] user_revision,
  input wire logic serial_flash_mode,
  input wire logic upset_detect_en,
  input wire logic readback_crc_err
);
  // two-stage synchronisers for the clock, select, direction, init, mode strap and data pin inputs
  logic [36:0] sync1_reg;
  logic [36:0] sync2_reg;
  logic cfg_clk_last_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      cfg_clk_last_reg <= 1'b0;
    end else begin
      sync1_reg <= {cfg_clock_in, cs_n, read_write_n, init_in, master_mode, data_in};
      sync2_reg <= sync1_reg;
      cfg_clk_last_reg <= sync2_reg[36];
    end
  end
  logic s_cfg_clk, s_cs_n, s_rdwr, s_init, s_master;
  logic [31:0] s_data;
  assign {s_cfg_clk, s_cs_n, s_rdwr, s_init, s_master, s_data} = sync2_reg;

  pcp_pkg::pcp_state_t state_reg;
  logic mode_sampled_reg;
  logic master_reg;
  logic [7:0] div_reg;
  logic rise;
  logic selected;
  // a stopped slave clock gives no edges, so loading just waits
  assign rise = master_reg ? (div_reg == 8'h00 && cfg_clock_out == 1'b0)
                           : (s_cfg_clk && !cfg_clk_last_reg);
  assign selected = !s_cs_n;

  // mode strap caught by a clocked process once init is released
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_sampled_reg <= 1'b0;
      master_reg <= 1'b0;
    end else if (!mode_sampled_reg && s_init) begin
      mode_sampled_reg <= 1'b1;
      master_reg <= s_master;
    end
  end

  // master clock divider, runs in master mode in every state except pcp_st_wait_init
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 8'h00;
      cfg_clock_out <= 1'b0;
      cfg_clock_oe <= 1'b0;
    end else begin
      cfg_clock_oe <= master_reg && mode_sampled_reg;
      if (!master_reg || state_reg == pcp_pkg::pcp_st_wait_init) begin
        div_reg <= 8'h00;
        cfg_clock_out <= 1'b0;
      end else if (div_reg == 8'(pcp_pkg::CFG_CLK_HALF_CYC - 1)) begin
        div_reg <= 8'h00;
        cfg_clock_out <= !cfg_clock_out;
      end else begin
        div_reg <= 8'(div_reg + 1'b1);
      end
    end
  end

  // width detection, word assembly and sync search on write edges
  pcp_pkg::pcp_width_t width_reg;
  logic mark_seen_reg;
  logic sync_seen_reg;
  logic [31:0] asm_reg;
  logic [1:0] asm_cnt_reg;
  logic word_valid_reg;
  logic [31:0] word_reg;
  logic fifo_ready;
  logic write_edge;
  logic [31:0] asm_next;
  logic asm_full;
  logic rdwr_seen_reg;
  logic abort_event;
  logic [2:0] abort_cnt_reg;
  assign write_edge = rise && selected && !s_rdwr && !abort_event
                      && state_reg == pcp_pkg::pcp_st_load;

  function automatic logic [1:0] lanes_per_word(input pcp_pkg::pcp_width_t w);
    case (w)
      pcp_pkg::pcp_w8: lanes_per_word = 2'h3;
      pcp_pkg::pcp_w16: lanes_per_word = 2'h1;
      default: lanes_per_word = 2'h0;
    endcase
  endfunction : lanes_per_word

  always_comb begin
    case (width_reg)
      pcp_pkg::pcp_w8: asm_next = {asm_reg[23:0], s_data[7:0]};
      pcp_pkg::pcp_w16: asm_next = {asm_reg[15:0], s_data[15:0]};
      default: asm_next = s_data;
    endcase
  end
  assign asm_full = (asm_cnt_reg == lanes_per_word(width_reg));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      width_reg <= pcp_pkg::pcp_w_none;
      mark_seen_reg <= 1'b0;
      sync_seen_reg <= 1'b0;
      asm_reg <= pcp_pkg::DATA_RST;
      asm_cnt_reg <= 2'h0;
      word_valid_reg <= 1'b0;
      word_reg <= pcp_pkg::DATA_RST;
    end else begin
      word_valid_reg <= 1'b0;
      if (abort_event || state_reg != pcp_pkg::pcp_st_load) begin
        // an abort during loading forces a fresh width search and resync; a restart only resyncs at the kept width
        width_reg <= (state_reg == pcp_pkg::pcp_st_load) ? pcp_pkg::pcp_w_none : width_reg;
        mark_seen_reg <= 1'b0;
        sync_seen_reg <= (state_reg == pcp_pkg::pcp_st_done) ? sync_seen_reg : 1'b0;
        asm_cnt_reg <= 2'h0;
      end else if (write_edge && width_reg == pcp_pkg::pcp_w_none) begin
        if (mark_seen_reg && s_data == pcp_pkg::WIDTH_32_KEY) begin
          width_reg <= pcp_pkg::pcp_w32;
        end else if (mark_seen_reg && s_data[15:0] == pcp_pkg::WIDTH_16_KEY) begin
          width_reg <= pcp_pkg::pcp_w16;
        end else if (mark_seen_reg && s_data[7:0] == pcp_pkg::WIDTH_8_KEY) begin
          width_reg <= pcp_pkg::pcp_w8;
        end
        mark_seen_reg <= (s_data[7:0] == pcp_pkg::WIDTH_MARK);
      end else if (write_edge) begin
        asm_reg <= asm_next;
        asm_cnt_reg <= asm_full ? 2'h0 : 2'(asm_cnt_reg + 1'b1);
        if (asm_full && !sync_seen_reg) begin
          sync_seen_reg <= (asm_next == pcp_pkg::SYNC_WORD);
        end else if (asm_full && fifo_ready) begin
          // a word offered while busy is lost; the controller must honour busy
          word_valid_reg <= 1'b1;
          word_reg <= asm_next;
        end
      end
    end
  end

  // buffer between the link and the configuration engine
  logic cfg_valid;
  logic cfg_take;
  logic [31:0] cfg_word;
  pcp_fifo #(
    .WIDTH(pcp_pkg::DATA_W),
    .DEPTH(pcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(word_valid_reg),
    .in_ready(fifo_ready),
    .in_data(word_reg),
    .out_valid(cfg_valid),
    .out_ready(cfg_take),
    .out_data(cfg_word)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= !fifo_ready;
    end
  end

  // configuration engine: paced consumer, running xor check
  logic [7:0] drain_reg;
  logic [15:0] word_cnt_reg;
  logic [31:0] check_reg;
  logic crc_err_reg;
  logic load_ok;
  logic load_bad;
  logic [7:0] hold_reg;
  assign cfg_take = cfg_valid && drain_reg == 8'h00 && state_reg == pcp_pkg::pcp_st_load;
  assign load_ok = cfg_take && word_cnt_reg == pcp_pkg::CFG_WORDS && cfg_word == check_reg;
  assign load_bad = cfg_take && word_cnt_reg == pcp_pkg::CFG_WORDS && cfg_word != check_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drain_reg <= 8'h00;
      word_cnt_reg <= 16'h0000;
      check_reg <= pcp_pkg::DATA_RST;
    end else if (state_reg != pcp_pkg::pcp_st_load) begin
      drain_reg <= 8'h00;
      word_cnt_reg <= (state_reg == pcp_pkg::pcp_st_done) ? word_cnt_reg : 16'h0000;
      check_reg <= (state_reg == pcp_pkg::pcp_st_done) ? check_reg : pcp_pkg::DATA_RST;
    end else if (cfg_take) begin
      drain_reg <= 8'(pcp_pkg::DRAIN_CYC - 1);
      word_cnt_reg <= 16'(word_cnt_reg + 1'b1);
      check_reg <= check_reg ^ cfg_word;
    end else if (drain_reg != 8'h00) begin
      drain_reg <= 8'(drain_reg - 1'b1);
    end
  end

  // main sequence
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= pcp_pkg::pcp_st_wait_init;
      crc_err_reg <= 1'b0;
      hold_reg <= 8'h00;
    end else begin
      case (state_reg)
        pcp_pkg::pcp_st_wait_init: begin
          if (s_init) begin
            state_reg <= pcp_pkg::pcp_st_load;
          end
        end
        pcp_pkg::pcp_st_load: begin
          if (load_ok) begin
            state_reg <= pcp_pkg::pcp_st_done;
          end else if (load_bad) begin
            crc_err_reg <= 1'b1;
            if (fallback_option && !serial_flash_mode) begin
              state_reg <= pcp_pkg::pcp_st_fallback;
              hold_reg <= 8'(pcp_pkg::REV_HOLD_CYC - 1);
            end else begin
              state_reg <= pcp_pkg::pcp_st_error;
            end
          end
        end
        pcp_pkg::pcp_st_done: begin
          if (multi_image_req && multi_image_en && !serial_flash_mode) begin
            state_reg <= pcp_pkg::pcp_st_multi;
            hold_reg <= 8'(pcp_pkg::REV_HOLD_CYC - 1);
          end
        end
        pcp_pkg::pcp_st_fallback, pcp_pkg::pcp_st_multi: begin
          if (hold_reg == 8'h00) begin
            state_reg <= pcp_pkg::pcp_st_load;
          end else begin
            hold_reg <= 8'(hold_reg - 1'b1);
          end
        end
        default: begin
          state_reg <= pcp_pkg::pcp_st_error;
        end
      endcase
    end
  end

  // abort detection: direction change seen on an edge while selected
  logic readback_active;
  assign readback_active = selected && s_rdwr && !abort_event && abort_cnt_reg == 3'h0;
  assign abort_event = rise && selected && (s_rdwr != rdwr_seen_reg);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdwr_seen_reg <= 1'b0;
      abort_cnt_reg <= 3'h0;
    end else begin
      if (!selected || rise) begin
        rdwr_seen_reg <= s_rdwr; // changes while deselected are legal
      end
      if (abort_event && s_rdwr) begin
        abort_cnt_reg <= pcp_pkg::ABORT_EDGES;
      end else if (abort_event || !s_rdwr || !selected) begin
        abort_cnt_reg <= 3'h0;
      end else if (rise && abort_cnt_reg != 3'h0) begin
        abort_cnt_reg <= 3'(abort_cnt_reg - 1'b1);
      end
    end
  end

  // readback: words leave msb lane first at the detected width
  logic [1:0] rb_lane_reg;
  logic [31:0] rb_word_reg;
  logic [15:0] rb_index_reg;
  logic [7:0] status_byte;
  assign status_byte = {!crc_err_reg, sync_seen_reg, readback_active, abort_cnt_reg == 3'h0,
                        pcp_pkg::ST_LOW_BITS};

  function automatic logic [31:0] rb_lanes(input logic [31:0] w, input logic [1:0] lane,
                                          input pcp_pkg::pcp_width_t wd);
    rb_lanes = 32'hffffffff;
    case (wd)
      pcp_pkg::pcp_w8: rb_lanes[7:0] = w[8*(3-lane) +: 8];
      pcp_pkg::pcp_w16: rb_lanes[15:0] = w[16*(1-lane[0]) +: 16];
      default: rb_lanes = w;
    endcase
  endfunction : rb_lanes

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_out <= pcp_pkg::DATA_RST;
      data_oe <= pcp_pkg::DATA_RST;
      rb_lane_reg <= 2'h0;
      rb_word_reg <= pcp_pkg::DATA_RST;
      rb_index_reg <= 16'h0000;
    end else begin
      // enable follows select and direction, and is masked on an abort edge; drops as soon as either goes
      data_oe <= {32{selected && s_rdwr && !abort_event}};
      if (rise && abort_cnt_reg != 3'h0 && selected) begin
        data_out <= {24'hffffff, status_byte};
      end else if (rise && readback_active) begin
        data_out <= rb_lanes(rb_word_reg, rb_lane_reg, width_reg);
        if (rb_lane_reg == lanes_per_word(width_reg)) begin
          rb_lane_reg <= 2'h0;
          rb_index_reg <= 16'(rb_index_reg + 1'b1);
          rb_word_reg <= check_reg ^ {16'h0000, 16'(rb_index_reg + 1'b1)};
        end else begin
          rb_lane_reg <= 2'(rb_lane_reg + 1'b1);
        end
      end else if (!selected) begin
        rb_lane_reg <= 2'h0;
      end
    end
  end

  // status pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      init_out <= 1'b0;
      init_oe <= 1'b0;
      chain_select_out_n <= 1'b1;
      revision_select <= pcp_pkg::REV_SEL_RST;
      revision_select_oe <= 2'h0;
    end else begin
      done <= (state_reg == pcp_pkg::pcp_st_done);
      init_out <= 1'b0;
      // before the strap is taken the init pin is left as an input
      init_oe <= mode_sampled_reg
                 && (crc_err_reg || (upset_detect_en && readback_crc_err));
      // once this device is done, selects pass to the next one in the chain
      chain_select_out_n <= !(state_reg == pcp_pkg::pcp_st_done && selected);
      if (state_reg == pcp_pkg::pcp_st_fallback) begin
        revision_select <= 2'h0;
        revision_select_oe <= 2'h3;
      end else if (state_reg == pcp_pkg::pcp_st_multi) begin
        revision_select <= user_revision;
        revision_select_oe <= 2'h3;
      end else begin
        revision_select <= pcp_pkg::REV_SEL_RST;
        revision_select_oe <= 2'h0;
      end
    end
  end
endmodule : pcp_top

// ---- shared/pcp_pkg.sv ----
// constants shared by the parallel configuration port and its fifo
// assumes a 25 MHz system clock; all times are converted to cycles here
package pcp_pkg;
  localparam int SYS_CLK_PERIOD_NS = 40;
  // master mode configuration clock: half period in ns, rounded up to cycles
  localparam int CFG_CLK_HALF_NS = 160;
  localparam int CFG_CLK_HALF_CYC = (CFG_CLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // least time the revision select pins are driven before a reload
  localparam int REV_HOLD_NS = 1000;
  localparam int REV_HOLD_CYC = (REV_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // the configuration engine consumes one word every so many cycles
  localparam int DRAIN_CYC = 4;
  // abort status is shown for this many configuration clock edges
  localparam logic [2:0] ABORT_EDGES = 3'h4;
  // data path
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;
  // bus width detection and synchronisation patterns
  localparam logic [7:0] WIDTH_MARK = 8'hbb;
  localparam logic [7:0] WIDTH_8_KEY = 8'h11;
  localparam logic [15:0] WIDTH_16_KEY = 16'h1122;
  localparam logic [31:0] WIDTH_32_KEY = 32'h11220044;
  localparam logic [31:0] SYNC_WORD = 32'haa995566;
  // payload words after sync, followed by one check word (xor of payload)
  localparam logic [15:0] CFG_WORDS = 16'h0010;
  // abort status word field positions
  localparam int ST_CFG_ERR_N = 7;
  localparam int ST_SYNC = 6;
  localparam int ST_READBACK = 5;
  localparam int ST_ABORT_N = 4;
  localparam logic [3:0] ST_LOW_BITS = 4'hf;
  // reset values
  localparam logic [31:0] DATA_RST = 32'h00000000;
  localparam logic [1:0] REV_SEL_RST = 2'h3;
  typedef enum logic [1:0] {
    pcp_w_none,
    pcp_w8,
    pcp_w16,
    pcp_w32
  } pcp_width_t;
  typedef enum logic [2:0] {
    pcp_st_wait_init,
    pcp_st_load,
    pcp_st_done,
    pcp_st_error,
    pcp_st_fallback,
    pcp_st_multi
  } pcp_state_t;
endpackage : pcp_pkg

// ---- testbench/parallel_config_port_test.sv ----
// self-checking bench for the parallel configuration port
// assumes the design, the controller model and the checker are compiled first
`timescale 1ns/1ps
module parallel_config_port_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic init_hold_n = 1'b0;
  logic master_mode = 1'b1;
  logic fallback_option = 1'b0;
  logic multi_image_en = 1'b0;
  logic multi_image_req = 1'b0;
  logic serial_flash_mode = 1'b0;
  logic upset_detect_en = 1'b0;
  logic readback_crc_err = 1'b0;
  logic [1:0] user_revision = 2'h0;
  logic [31:0] chk;
  int err_count = 0;
  int check_count = 0;
  wire logic host_clk, cfg_clock_in, cfg_clock_out, cfg_clock_oe, cs_n, read_write_n, busy;
  wire logic chain_select_out_n, done, init_in, init_out, init_oe;
  wire logic [31:0] data_in, data_out, data_oe;
  wire logic [1:0] revision_select, revision_select_oe;
  // master clock overrides the controller's; init is open drain with a pull-up
  assign cfg_clock_in = cfg_clock_oe ? cfg_clock_out : host_clk;
  assign init_in = init_oe ? 1'b0 : init_hold_n;
  pcp_top i_dut (.*);
  pcp_host_model h (.*);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic do_reset;
    nrst = 1'b0;
    init_hold_n = 1'b0;
    tick(6);
    nrst = 1'b1;
    tick(3);
    init_hold_n = 1'b1;
    tick(10);
  endtask : do_reset
  task automatic wait_sig(input logic on_init);
    int n;
    n = 0;
    while ((on_init ? init_oe : done) !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    #2;
  endtask : wait_sig
  function automatic logic [31:0] width_key(input int w);
    if (w == 8) return {24'h0, pcp_pkg::WIDTH_8_KEY};
    if (w == 16) return {16'h0, pcp_pkg::WIDTH_16_KEY};
    return pcp_pkg::WIDTH_32_KEY;
  endfunction : width_key
  task automatic start(input int w);
    h.sel(1'b0, 1'b1);
    h.edge_put({24'h0, pcp_pkg::WIDTH_MARK});
    h.edge_put(width_key(w));
    h.put_word(w, pcp_pkg::SYNC_WORD);
  endtask : start
  // random payload; the check word is the xor of it, spoiled on request
  task automatic load(input int w, input logic bad);
    logic [31:0] p;
    chk = 32'h0;
    start(w);
    repeat (pcp_pkg::CFG_WORDS) begin
      p = $urandom;
      chk ^= p;
      h.put_word(w, p);
    end
    h.put_word(w, bad ? ~chk : chk);
  endtask : load
  initial begin
    logic [31:0] d;
    int k;
    d = $urandom(19379);
    // a real falling edge, so the asynchronous resets act before the first clock
    #1 nrst = 1'b0;
    tick(6);
    cmp({done, init_oe, chain_select_out_n, revision_select, revision_select_oe}, 32'h1c, "rst");
    cmp(data_oe, 32'h0, "rst oe");
    nrst = 1'b1;
    tick(20);
    cmp(cfg_clock_out, 32'h0, "clock while init low");
    init_hold_n = 1'b1;
    tick(14);
    cmp(cfg_clock_oe, 32'h1, "master clock oe");
    k = 0;
    repeat (16) begin
      tick(1);
      k += cfg_clock_out;
    end
    cmp(k, 32'h8, "master clock duty");
    master_mode = 1'b0;
    do_reset;
    h.sel(1'b1, 1'b0);
    repeat (3) begin
      h.edge_get(d);
      cmp(data_oe, 32'h0, "deselected drive");
    end
    load(8, 1'b0);
    wait_sig(1'b0);
    cmp(done, 32'h1, "done");
    cmp(init_oe, 32'h0, "init quiet");
    cmp(chain_select_out_n, 32'h0, "chain select");
    cmp(busy, 32'h0, "busy while paced");
    h.sel(1'b1, 1'b1);
    // the check word cancels the running xor, so readback word n reads back as n
    for (k = 0; k < 8; k++) begin
      h.edge_get(d);
      cmp(d, {24'hffffff, 8'((k >> 2) >> (8 * (3 - (k & 3))))}, "readback byte");
      cmp(data_oe, 32'hffffffff, "readback oe");
    end
    upset_detect_en = 1'b1;
    readback_crc_err = 1'b1;
    tick(3);
    cmp(init_oe, 32'h1, "upset pull");
    readback_crc_err = 1'b0;
    tick(3);
    cmp(init_oe, 32'h0, "upset release");
    upset_detect_en = 1'b0;
    h.sel(1'b0, 1'b0);
    multi_image_en = 1'b1;
    user_revision = 2'($urandom);
    multi_image_req = 1'b1;
    tick(4);
    cmp({revision_select_oe, revision_select}, {2'h3, user_revision}, "multi revision");
    multi_image_req = 1'b0;
    tick(40);
    multi_image_en = 1'b0;
    do_reset;
    start(16);
    h.flip(1'b1);
    // the offending edge itself aborts and clears the sync search; status follows it
    h.edge_get(d);
    chk = ~((32'h1 << pcp_pkg::ST_SYNC) | (32'h1 << pcp_pkg::ST_READBACK)
            | (32'h1 << pcp_pkg::ST_ABORT_N));
    repeat (4) begin
      h.edge_get(d);
      cmp(d, chk, "status");
    end
    h.flip(1'b0);
    tick(6);
    cmp(data_oe, 32'h0, "abort turnoff");
    for (k = 0; k < 3; k++) begin
      fallback_option = (k != 0);
      serial_flash_mode = (k == 2);
      do_reset;
      load(32, 1'b1);
      wait_sig(1'b1);
      tick(2);
      cmp(init_oe, 32'h1, "crc error");
      cmp(revision_select_oe, (k == 1) ? 32'h3 : 32'h0, "fallback oe");
      if (k == 1) begin
        cmp(revision_select, 32'h0, "fallback revision");
        nrst = 1'b0;
        #5;
        cmp({init_oe, revision_select_oe}, 32'h0, "async reset");
      end
    end
    end_sim;
  end
  // whole run is about 1500 cycles; this 50000-cycle limit leaves ample margin
  initial begin
    #2000000;
    err_count++;
    end_sim;
  end
endmodule : parallel_config_port_test

// ---- testbench/pcp_host_model.sv ----
// far-side configuration controller: select, direction, clock and data
// assumes the bench resolves the shared clock wire; the shared data wires are resolved in this model
`timescale 1ns/1ps
module pcp_host_model (
  // system
  input wire logic clk_sys,
  // from the device
  input wire logic busy,
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe,
  // to the device
  output logic host_clk,
  output logic cs_n,
  output logic read_write_n,
  output logic [31:0] data_in
);
  logic [31:0] drv = 32'h0;
  logic drv_en = 1'b0;
  initial begin
    host_clk = 1'b0;
    cs_n = 1'b1;
    read_write_n = 1'b0;
  end
  // a released bus shows the inverse of its last level, never a stale copy
  assign data_in = data_oe[0] ? data_out : (drv_en ? drv : ~drv);
  task automatic sel(input logic rw, input logic on);
    cs_n = 1'b1;
    drv_en = 1'b0;
    #40 read_write_n = rw;
    #40 cs_n = !on;
  endtask : sel
  // breaks the direction rule on purpose to force an abort
  task automatic flip(input logic rw);
    drv_en = 1'b0;
    #40 read_write_n = rw;
  endtask : flip
  // clock rests low between edges, so loading simply pauses
  task automatic edge_put(input logic [31:0] d);
    // a hang here is left to the bench watchdog, which counts it as a failure
    while (busy === 1'b1) begin
      @(posedge clk_sys);
      #2;
    end
    drv = d;
    drv_en = 1'b1;
    #160 host_clk = 1'b1;
    #160 host_clk = 1'b0;
  endtask : edge_put
  task automatic edge_get(output logic [31:0] d);
    #160 host_clk = 1'b1;
    #160 host_clk = 1'b0;
    #80 d = data_in;
  endtask : edge_get
  task automatic put_word(input int w, input logic [31:0] v);
    for (int i = 0; i < 32 / w; i++) edge_put(v >> (32 - w * (i + 1)));
  endtask : put_word
endmodule : pcp_host_model

// ---- testbench/pcp_top_sva.sv ----
// pin-level checker for the parallel configuration port
// assumes it is bound onto pcp_top and sees only that module's ports
`timescale 1ns/1ps
module pcp_top_sva (
  // system
  input wire logic clk_sys,
  input wire logic nrst,
  // pins
  input wire logic cfg_clock_out,
  input wire logic cfg_clock_oe,
  input wire logic [31:0] data_oe,
  input wire logic cs_n,
  input wire logic read_write_n,
  input wire logic chain_select_out_n,
  input wire logic done,
  input wire logic init_out,
  input wire logic init_oe,
  input wire logic [1:0] revision_select,
  input wire logic [1:0] revision_select_oe,
  // options
  input wire logic fallback_option,
  input wire logic multi_image_en,
  input wire logic multi_image_req,
  input wire logic serial_flash_mode,
  input wire logic upset_detect_en,
  input wire logic readback_crc_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [3:0] quiet_cnt;
  logic rev_off_q;
  wire rev_off = serial_flash_mode || (!fallback_option && !multi_image_en);
  // pins are synchronised, so turn-off is allowed a few cycles of slack
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) quiet_cnt <= 4'h0;
    else if (!cs_n && read_write_n) quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rev_off_q <= 1'b0;
    else rev_off_q <= rev_off;
  end
  a_quiet_bus_hiz: assert property (quiet_cnt >= 4'h6 |-> data_oe == 32'h0)
    else $error("data driven while port idle");
  a_drive_needs_read: assert property ($rose(data_oe[0]) |->
    $past(read_write_n, 2) && !$past(cs_n, 2)) else $error("drive without selected read");
  a_lanes_equal: assert property (data_oe == 32'h0 || data_oe == 32'hffffffff)
    else $error("data enables split");
  a_done_holds: assert property (done && !(multi_image_req && multi_image_en) |=> done)
    else $error("done dropped");
  a_init_open_drain: assert property (init_oe |-> !init_out)
    else $error("init driven high");
  a_upset_pull: assert property (upset_detect_en && readback_crc_err |-> ##[0:2] init_oe)
    else $error("upset error not on init");
  a_rev_released: assert property (rev_off && rev_off_q |-> revision_select_oe == 2'h0)
    else $error("revision select driven");
  a_rev_fallback_low: assert property (revision_select_oe == 2'h3 && !multi_image_en
    |-> revision_select == 2'h0) else $error("fallback revision not low");
  a_chain_needs_done: assert property (!chain_select_out_n |-> done)
    else $error("chain select before done");
  a_master_half: assert property (cfg_clock_oe && $rose(cfg_clock_out)
    |=> cfg_clock_out [*3] ##1 !cfg_clock_out) else $error("master clock half period");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |-> !done &&
    data_oe == 32'h0 && chain_select_out_n && revision_select_oe == 2'h0)
    else $error("outputs active in reset");
endmodule : pcp_top_sva

bind pcp_top pcp_top_sva i_pcp_sva (.*);
